// *** hw/ubt_pkg.sv ***
// constants shared by the serial data buffer and baud timing logic
package ubt_pkg;
    localparam logic [7:0] ADDR_DATA_BUF   = 8'h99;
    localparam logic [7:0] DATA_BUF_RESET  = 8'h00;
    localparam logic [1:0] PRE_SYS_DIV12   = 2'h0;
    localparam logic [1:0] PRE_SYS_DIV4    = 2'h1;
    localparam logic [1:0] PRE_SYS_DIV48   = 2'h2;
    localparam logic [1:0] PRE_EXT_DIV8    = 2'h3;
    localparam logic [5:0] DIV_BY_12       = 6'h0c;
    localparam logic [5:0] DIV_BY_4        = 6'h04;
    localparam logic [5:0] DIV_BY_48       = 6'h30;
    localparam logic [5:0] DIV_BY_8        = 6'h08;
    localparam logic [7:0] TIMER_TOP       = 8'hff;
    localparam logic [8:0] TIMER_SPAN      = 9'h100;
    localparam logic [2:0] LAST_DATA_BIT   = 3'h7;
    localparam logic       LINE_IDLE       = 1'b1;
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA_OR_STOP} ubt_txst_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubt_rxst_e;
endpackage : ubt_pkg

// *** hw/ubt_baud_if.sv ***
// timing enables from the baud generator to the serial engines
`timescale 1ns/1ps
`default_nettype none
interface ubt_baud_if;
    logic timer_tick;
    logic bit_tick;
    modport gen (output timer_tick, output bit_tick);
    modport use_side (input timer_tick, input bit_tick);
endinterface : ubt_baud_if
`default_nettype wire

// *** hw/ubt_baud_gen.sv ***
// prescaler and 8-bit auto-reload baud timer
`timescale 1ns/1ps
`default_nettype none
module ubt_baud_gen (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // configuration
    input  wire logic [1:0] prescale_sel,
    input  wire logic       direct_clk_sel,
    input  wire logic [7:0] reload,
    input  wire logic       ext_clk,
    // enables out
    ubt_baud_if.gen         baud
);
    logic [5:0] pre_r, pre_nxt, div_sel;
    logic [7:0] tcnt_r, tcnt_nxt;
    logic       half_r, half_nxt, ext_q_r, ext_rise, pre_step, tick, ovf;

    assign ext_rise = ext_clk & ~ext_q_r;

    always_comb begin
        case (prescale_sel) // see (RULE_06)
            ubt_pkg::PRE_SYS_DIV12: div_sel = ubt_pkg::DIV_BY_12;
            ubt_pkg::PRE_SYS_DIV4:  div_sel = ubt_pkg::DIV_BY_4;
            ubt_pkg::PRE_SYS_DIV48: div_sel = ubt_pkg::DIV_BY_48;
            default:                div_sel = ubt_pkg::DIV_BY_8;
        endcase
        // external input counts its own rising edges, not system cycles
        pre_step = (prescale_sel == ubt_pkg::PRE_EXT_DIV8) ? ext_rise : 1'b1;
        pre_nxt  = pre_r;
        tick     = 1'b0;
        if (pre_step) begin
            if (pre_r >= div_sel - 6'h01) begin
                pre_nxt = 6'h00;
                tick    = 1'b1;
            end else begin
                pre_nxt = pre_r + 6'h01;
            end
        end
        if (direct_clk_sel) begin
            tick = 1'b1; // see (RULE_07)
        end
        ovf      = tick && (tcnt_r == ubt_pkg::TIMER_TOP);
        tcnt_nxt = tcnt_r;
        if (tick) begin
            tcnt_nxt = ovf ? reload : tcnt_r + 8'h01; // see (RULE_11)
        end
        half_nxt = ovf ? ~half_r : half_r; // overflow halved, see (RULE_11)
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_r   <= 6'h00;
            tcnt_r  <= 8'h00;
            half_r  <= 1'b0;
            ext_q_r <= 1'b0;
        end else begin
            pre_r   <= pre_nxt;
            tcnt_r  <= tcnt_nxt;
            half_r  <= half_nxt;
            ext_q_r <= ext_clk;
        end
    end

    assign baud.timer_tick = tick;
    assign baud.bit_tick   = ovf & half_r;

    AST_DIRECT_EVERY_CYCLE: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_07)
        direct_clk_sel |-> baud.timer_tick)
        else $error("direct clock select did not tick every cycle");
    AST_DIV4_SPACING: assert property (@(posedge clk) disable iff (!rst_n) // see (RULE_06)
        (baud.timer_tick && !direct_clk_sel && prescale_sel == ubt_pkg::PRE_SYS_DIV4
         && $stable(prescale_sel))
        ##1 (!direct_clk_sel && prescale_sel == ubt_pkg::PRE_SYS_DIV4)[*4]
        |-> $past(!baud.timer_tick, 1) && $past(!baud.timer_tick, 3) && baud.timer_tick)
        else $error("divide-by-4 prescale spacing wrong");
endmodule : ubt_baud_gen
`default_nettype wire

// *** hw/ubt_serial_port.sv ***
// serial data buffer with transmit and receive engines
// Summary of operation
// (RULE_01) one buffer address writes the transmit shifter and reads the receive latch.
// (RULE_02) a written byte is loaded into the transmit shifter and held until sent.
// (RULE_03) any write to the buffer starts a new frame with no other command.
// (RULE_04) a read of the buffer returns the receive latch, never outgoing data.
// (RULE_05) the buffer is 8 bits, msb bit 7, and resets to zero.
// (RULE_06) with direct select low, prescale 00/01/10/11 gives clk/12, clk/4, clk/48, ext/8.
// (RULE_07) with direct select high the timer runs on the system clock, prescale ignored.
// (RULE_08) software wanting 115200 bps at 24.5 MHz uses direct clock and reload 0x96.
// (RULE_09) software wanting 9600 bps at 22.1184 MHz uses clock/12 and reload 0xA0.
// (RULE_10) software wanting 57600 bps at 25 MHz uses direct clock and reload 0x27.
// (RULE_11) baud rate is timer clock over (256 minus reload), halved.
// (RULE_12) a frame is start bit, eight data bits lsb first, stop bit: ten bit times.
// (RULE_13) the transmit-done flag sets at the start of the stop bit and stays until cleared.
// (RULE_14) after a stop bit the latch loads only with the done flag clear and, if checking, stop high.
// (RULE_15) the receive latch keeps its byte between valid receptions.
`timescale 1ns/1ps
`default_nettype none
module ubt_serial_port (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // special function register port
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    // timer configuration
    input  wire logic [1:0] TIMER_PRESCALE_SELECT,
    input  wire logic       TIMER_DIRECT_CLOCK_SELECT,
    input  wire logic [7:0] TIMER_RELOAD_HIGH_BYTE,
    input  wire logic       EXTERNAL_CLOCK_INPUT,
    // frame control and flags
    input  wire logic       RECEIVE_ENABLE,
    input  wire logic       STOP_OR_NINTH_BIT_CHECK_ENABLE,
    input  wire logic       TRANSMIT_DONE_CLEAR,
    input  wire logic       RECEIVE_DONE_CLEAR,
    output logic            TRANSMIT_DONE_FLAG,
    output logic            RECEIVE_DONE_FLAG,
    // serial pins
    output logic            TXD,
    input  wire logic       RXD
);
    ubt_baud_if baud ();

    ubt_baud_gen u_baud (
        .clk            (CLK),
        .rst_n          (RST_N),
        .prescale_sel   (TIMER_PRESCALE_SELECT),
        .direct_clk_sel (TIMER_DIRECT_CLOCK_SELECT),
        .reload         (TIMER_RELOAD_HIGH_BYTE),
        .ext_clk        (EXTERNAL_CLOCK_INPUT),
        .baud           (baud.gen)
    );

    logic buf_sel, buf_wr, buf_rd;
    assign buf_sel = (SFR_ADDR == ubt_pkg::ADDR_DATA_BUF);
    assign buf_wr  = SFR_WR && buf_sel; // see (RULE_01)
    assign buf_rd  = SFR_RD && buf_sel; // see (RULE_01)

    // transmit engine
    ubt_pkg::ubt_txst_e tx_st_r, tx_st_nxt;
    logic [7:0] tx_sh_r, tx_sh_nxt;
    logic [3:0] tx_bit_r, tx_bit_nxt;
    logic       txd_nxt, ti_nxt;

    always_comb begin
        tx_st_nxt  = tx_st_r;
        tx_sh_nxt  = tx_sh_r;
        tx_bit_nxt = tx_bit_r;
        txd_nxt    = TXD;
        ti_nxt     = TRANSMIT_DONE_FLAG & ~TRANSMIT_DONE_CLEAR;
        if (buf_wr) begin
            // a write mid-frame abandons the old byte and restarts
            tx_sh_nxt = SFR_WDATA; // see (RULE_02)
            tx_st_nxt = ubt_pkg::TX_WAIT; // see (RULE_03)
            txd_nxt   = ubt_pkg::LINE_IDLE;
        end else if (baud.bit_tick) begin
            case (tx_st_r)
                ubt_pkg::TX_WAIT: begin
                    txd_nxt    = 1'b0; // see (RULE_12)
                    tx_bit_nxt = 4'h0;
                    tx_st_nxt  = ubt_pkg::TX_START;
                end
                ubt_pkg::TX_START, ubt_pkg::TX_DATA_OR_STOP: begin
                    if (tx_bit_r < 4'h8) begin
                        txd_nxt    = tx_sh_r[tx_bit_r[2:0]]; // lsb first, see (RULE_12)
                        tx_bit_nxt = tx_bit_r + 4'h1;
                        tx_st_nxt  = ubt_pkg::TX_DATA_OR_STOP;
                    end else if (tx_bit_r == 4'h8) begin
                        txd_nxt    = ubt_pkg::LINE_IDLE;
                        tx_bit_nxt = 4'h9;
                        ti_nxt     = 1'b1; // set wins over clear, see (RULE_13)
                    end else begin
                        tx_st_nxt = ubt_pkg::TX_IDLE;
                    end
                end
                default: tx_st_nxt = ubt_pkg::TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tx_st_r            <= ubt_pkg::TX_IDLE;
            tx_sh_r            <= ubt_pkg::DATA_BUF_RESET; // see (RULE_05)
            tx_bit_r           <= 4'h0;
            TXD                <= ubt_pkg::LINE_IDLE;
            TRANSMIT_DONE_FLAG <= 1'b0;
        end else begin
            tx_st_r            <= tx_st_nxt;
            tx_sh_r            <= tx_sh_nxt;
            tx_bit_r           <= tx_bit_nxt;
            TXD                <= txd_nxt;
            TRANSMIT_DONE_FLAG <= ti_nxt;
        end
    end

    // receive engine: own half-bit count, aligned to the start edge
    ubt_pkg::ubt_rxst_e rx_st_r, rx_st_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt, rx_lat_r, rx_lat_nxt;
    logic [9:0] rx_cnt_r, rx_cnt_nxt, half_len, rx_goal;
    logic [2:0] rx_bit_r, rx_bit_nxt;
    logic       ri_nxt, rx_load;

    assign half_len = {1'b0, ubt_pkg::TIMER_SPAN - {1'b0, TIMER_RELOAD_HIGH_BYTE}};

    always_comb begin
        rx_st_nxt  = rx_st_r;
        rx_sh_nxt  = rx_sh_r;
        rx_bit_nxt = rx_bit_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_load    = 1'b0;
        rx_goal    = (rx_st_r == ubt_pkg::RX_START) ? half_len : {half_len[8:0], 1'b0};
        if (rx_st_r != ubt_pkg::RX_IDLE && baud.timer_tick) begin
            rx_cnt_nxt = rx_cnt_r + 10'h001;
        end
        case (rx_st_r)
            ubt_pkg::RX_IDLE: begin
                rx_cnt_nxt = 10'h000;
                if (RECEIVE_ENABLE && !RXD) begin
                    rx_st_nxt = ubt_pkg::RX_START;
                end
            end
            default: begin
                if (baud.timer_tick && rx_cnt_nxt >= rx_goal) begin
                    rx_cnt_nxt = 10'h000;
                    if (rx_st_r == ubt_pkg::RX_START) begin
                        // a glitch shorter than half a bit is dropped
                        rx_st_nxt  = RXD ? ubt_pkg::RX_IDLE : ubt_pkg::RX_DATA;
                        rx_bit_nxt = 3'h0;
                    end else if (rx_st_r == ubt_pkg::RX_DATA) begin
                        rx_sh_nxt  = {RXD, rx_sh_r[7:1]}; // see (RULE_12)
                        rx_bit_nxt = rx_bit_r + 3'h1;
                        if (rx_bit_r == ubt_pkg::LAST_DATA_BIT) begin
                            rx_st_nxt = ubt_pkg::RX_STOP;
                        end
                    end else begin
                        rx_load   = !RECEIVE_DONE_FLAG &&
                                    (!STOP_OR_NINTH_BIT_CHECK_ENABLE || RXD); // see (RULE_14)
                        rx_st_nxt = ubt_pkg::RX_IDLE;
                    end
                end
            end
        endcase
        rx_lat_nxt = rx_load ? rx_sh_r : rx_lat_r; // see (RULE_15)
        ri_nxt     = rx_load | (RECEIVE_DONE_FLAG & ~RECEIVE_DONE_CLEAR);
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rx_st_r           <= ubt_pkg::RX_IDLE;
            rx_sh_r           <= 8'h00;
            rx_lat_r          <= ubt_pkg::DATA_BUF_RESET; // see (RULE_05)
            rx_cnt_r          <= 10'h000;
            rx_bit_r          <= 3'h0;
            RECEIVE_DONE_FLAG <= 1'b0;
            SFR_RDATA         <= 8'h00;
        end else begin
            rx_st_r           <= rx_st_nxt;
            rx_sh_r           <= rx_sh_nxt;
            rx_lat_r          <= rx_lat_nxt;
            rx_cnt_r          <= rx_cnt_nxt;
            rx_bit_r          <= rx_bit_nxt;
            RECEIVE_DONE_FLAG <= ri_nxt;
            SFR_RDATA         <= buf_rd ? rx_lat_r : 8'h00; // see (RULE_04)
        end
    end

    AST_WRITE_LOADS_SHIFTER: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_02)
        buf_wr |=> tx_sh_r == $past(SFR_WDATA) && tx_st_r == ubt_pkg::TX_WAIT)
        else $error("write did not load shifter or arm frame");
    AST_READ_GIVES_LATCH: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_04)
        buf_rd |=> SFR_RDATA == $past(rx_lat_r))
        else $error("buffer read did not return receive latch");
    AST_START_FOLLOWS_TICK: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_03)
        (tx_st_r == ubt_pkg::TX_WAIT && baud.bit_tick && !buf_wr) |=> !TXD)
        else $error("frame did not start with a low start bit");
    AST_TX_DONE_AT_STOP: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_13)
        ($rose(tx_bit_r == 4'h9) && !buf_wr) |-> TRANSMIT_DONE_FLAG && TXD)
        else $error("transmit done not set at stop bit");
    AST_TX_DONE_STICKY: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_13)
        (TRANSMIT_DONE_FLAG && !TRANSMIT_DONE_CLEAR) |=> TRANSMIT_DONE_FLAG)
        else $error("transmit done dropped without clear");
    AST_NO_LOAD_WHEN_FULL: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_14)
        RECEIVE_DONE_FLAG |=> $stable(rx_lat_r))
        else $error("latch overwritten while receive done set");
    AST_CHECKED_STOP: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_14)
        (rx_load && STOP_OR_NINTH_BIT_CHECK_ENABLE) |-> RXD ##1 RECEIVE_DONE_FLAG)
        else $error("load with bad stop bit under check");
    AST_LATCH_HOLDS: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_15)
        !rx_load |=> $stable(rx_lat_r))
        else $error("receive latch changed without reception");
    AST_WRITE_NOT_READ_BACK: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE_01)
        (buf_wr && !rx_load) |=> rx_lat_r == $past(rx_lat_r))
        else $error("write leaked into receive latch");
endmodule : ubt_serial_port
`default_nettype wire

// *** bench/ubt_remote_uart.sv ***
// remote serial partner: frame receiver on the device output, frame sender on its input
`timescale 1ns/1ps
`default_nettype none
module ubt_remote_uart #(
    parameter int BIT_CYC = 8
) (
    // clock
    input  wire logic clk,
    // serial lines seen from the remote end
    input  wire logic line_in,
    output logic      line_out
);
    logic [7:0]  got_byte;
    logic        got_stop;
    int unsigned got_count;

    initial begin
        line_out  = 1'b1;
        got_byte  = 8'h00;
        got_stop  = 1'b0;
        got_count = 0;
    end

    // centre sampling; a start glitch shorter than half a bit is dropped
    always begin
        @(negedge line_in);
        repeat (BIT_CYC / 2) @(posedge clk);
        if (line_in === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clk);
                got_byte[i] = line_in;
            end
            repeat (BIT_CYC) @(posedge clk);
            got_stop  = line_in;
            got_count = got_count + 1;
        end
    end

    // start low, data lsb first, chosen stop level, then idle high
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] frame;
        frame = {stop, d, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            line_out <= frame[i];
            repeat (BIT_CYC) @(posedge clk);
        end
        line_out <= 1'b1;
        repeat (BIT_CYC) @(posedge clk);
        // hand back off the edge so the caller reads settled flags
        @(negedge clk);
    endtask : send
endmodule : ubt_remote_uart
`default_nettype wire

// *** bench/ubt_serial_port_tb.sv ***
// self-checking bench for the serial data buffer and baud timing block
`timescale 1ns/1ps
`default_nettype none
module ubt_serial_port_tb;
    // last three entries are the software settings
    localparam logic       TB_DIR [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    localparam logic [1:0] TB_PRE [9] = '{2'h0, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h0, 2'h2};
    localparam logic [7:0] TB_RLD [9] = '{8'hf0, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff,
                                          8'h96, 8'ha0, 8'h27};
    logic       clk, rst_n, sfr_wr, sfr_rd, direct_sel, ext_clk, rx_en, chk_en;
    logic       tx_clr, rx_clr, tx_flag, rx_flag, txd, rxd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, reload, d;
    logic [1:0] pre_sel;
    int         miscompares, cmp_count, cycles, n;

    ubt_serial_port u_ubt_serial_port (.CLK(clk), .RST_N(rst_n), .SFR_ADDR(sfr_addr),
        .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
        .TIMER_PRESCALE_SELECT(pre_sel), .TIMER_DIRECT_CLOCK_SELECT(direct_sel),
        .TIMER_RELOAD_HIGH_BYTE(reload), .EXTERNAL_CLOCK_INPUT(ext_clk),
        .RECEIVE_ENABLE(rx_en), .STOP_OR_NINTH_BIT_CHECK_ENABLE(chk_en),
        .TRANSMIT_DONE_CLEAR(tx_clr), .RECEIVE_DONE_CLEAR(rx_clr),
        .TRANSMIT_DONE_FLAG(tx_flag), .RECEIVE_DONE_FLAG(rx_flag), .TXD(txd), .RXD(rxd));
    // direct clock with reload 0xfc gives 8 cycles a bit
    ubt_remote_uart #(.BIT_CYC(8)) u_remote (.clk(clk), .line_in(txd), .line_out(rxd));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // external clock at half the system rate: 16 system cycles per timer tick at ext/8
    always @(posedge clk) ext_clk <= (ext_clk === 1'b1) ? 1'b0 : 1'b1;
    // slowest setting needs about 23000 cycles for one frame
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] w);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= w;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
    endtask : sfr_write
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] r);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd   <= 1'b0;
        @(negedge clk);
        r = sfr_rdata;
    endtask : sfr_read
    task automatic clear_flags();
        @(posedge clk);
        tx_clr <= 1'b1;
        rx_clr <= 1'b1;
        @(posedge clk);
        tx_clr <= 1'b0;
        rx_clr <= 1'b0;
        @(negedge clk);
    endtask : clear_flags
    task automatic wait_txd(input logic v);
        n = 0;
        while (txd !== v && n < 20000) begin
            @(negedge clk);
            n++;
        end
        check(8'(txd), 8'(v), "tx line level");
    endtask : wait_txd

    task automatic t_reset();
        check({txd, tx_flag, rx_flag}, 8'h04, "idle outputs after reset");
        sfr_read(ubt_pkg::ADDR_DATA_BUF, d);
        check(d, 8'h00, "buffer reset value");
    endtask : t_reset
    task automatic t_transmit();
        logic        prev;
        int unsigned n0;
        n0 = u_remote.got_count;
        sfr_write(8'h98, 8'h00);
        repeat (40) @(negedge clk);
        check(8'(u_remote.got_count - n0), 8'h00, "stray frame");
        sfr_write(ubt_pkg::ADDR_DATA_BUF, 8'h5a);
        prev = txd;
        n = 0;
        while (tx_flag !== 1'b1 && n < 400) begin
            prev = txd;
            @(negedge clk);
            n++;
        end
        check(8'({prev, txd}), 8'h01, "done flag vs stop bit");
        repeat (16) @(negedge clk);
        check(u_remote.got_byte, 8'h5a, "sent byte");
        check(8'(u_remote.got_stop), 8'h01, "stop level");
        check(8'(tx_flag), 8'h01, "done flag sticky");
        sfr_read(ubt_pkg::ADDR_DATA_BUF, d);
        check(d, 8'h00, "read returns latch");
        clear_flags();
        check(8'(tx_flag), 8'h00, "done flag cleared");
    endtask : t_transmit
    task automatic t_receive();
        u_remote.send(8'h3c, 1'b1);
        check(8'(rx_flag), 8'h01, "receive flag set");
        sfr_read(ubt_pkg::ADDR_DATA_BUF, d);
        check(d, 8'h3c, "received byte");
        sfr_read(8'h98, d);
        check(d, 8'h00, "unmapped read");
        u_remote.send(8'hc3, 1'b1);
        sfr_read(ubt_pkg::ADDR_DATA_BUF, d);
        check(d, 8'h3c, "overrun keeps first");
        clear_flags();
        chk_en <= 1'b1;
        u_remote.send(8'h81, 1'b0);
        check(8'(rx_flag), 8'h00, "bad stop refused");
        sfr_read(ubt_pkg::ADDR_DATA_BUF, d);
        check(d, 8'h3c, "latch held");
        chk_en <= 1'b0;
        u_remote.send(8'h81, 1'b0);
        sfr_read(ubt_pkg::ADDR_DATA_BUF, d);
        check({d[7:1], rx_flag}, 8'h81, "stop unchecked loads");
        clear_flags();
        chk_en <= 1'b1;
        u_remote.send(8'h42, 1'b1);
        sfr_read(ubt_pkg::ADDR_DATA_BUF, d);
        check({d[7:1], rx_flag}, 8'h43, "good stop under check");
        chk_en <= 1'b0;
        rx_en  <= 1'b0;
        clear_flags();
        u_remote.send(8'h24, 1'b1);
        sfr_read(ubt_pkg::ADDR_DATA_BUF, d);
        check({d[7:1], rx_flag}, 8'h42, "receiver disabled keeps latch");
        rx_en  <= 1'b1;
    endtask : t_receive
    task automatic t_baud();
        int div;
        int exp_bit;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            direct_sel <= TB_DIR[i];
            pre_sel    <= TB_PRE[i];
            reload     <= TB_RLD[i];
            div = TB_DIR[i] ? 1 : (TB_PRE[i] == 2'h0) ? 12 : (TB_PRE[i] == 2'h1) ? 4 :
                  (TB_PRE[i] == 2'h2) ? 48 : 16;
            sfr_write(ubt_pkg::ADDR_DATA_BUF, 8'h55);
            wait_txd(1'b0);
            wait_txd(1'b1);
            wait_txd(1'b0);
            n = 0;
            while (txd === 1'b0 && n < 3000) begin
                @(negedge clk);
                n++;
            end
            // full width compare: slow settings give bit times above 255 cycles
            exp_bit = 2 * (256 - TB_RLD[i]) * div;
            cmp_count++;
            if (n != exp_bit) begin
                miscompares++;
                $display("CHECK FAILED %0t bit time got %0d exp %0d", $time, n, exp_bit);
            end
            while (tx_flag !== 1'b1 && n < 30000) begin
                @(negedge clk);
                n++;
            end
            clear_flags();
        end
    endtask : t_baud

    task automatic close_out();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    initial begin
        {rst_n, sfr_wr, sfr_rd, chk_en, tx_clr, rx_clr, pre_sel} = '0;
        {direct_sel, rx_en, reload, sfr_addr, sfr_wdata} = {2'b11, 8'hfc, 16'h0000};
        {miscompares, cmp_count, cycles} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_reset();
        t_transmit();
        t_receive();
        t_baud();
        close_out();
    end
endmodule : ubt_serial_port_tb
`default_nettype wire
